// file: include/pin_mux_pkg.sv
/*
 * Package for the event flag register and the multi-function pin one mux.
 * Holds register offsets, field positions, reset values, mux codes,
 * timing counts and the packed structs that carry grouped signals.
 * Assumes a 250 MHz core clock.
 */
`default_nettype none

package pin_mux_pkg;

	// Register offsets on the control bus
	localparam logic [7:0] OFS_LIVE_EVENT_FLAGS      = 8'h61;
	localparam logic [7:0] OFS_PIN1_FUNCTION_CONTROL = 8'h62;
	localparam logic [7:0] OFS_BUTTON_CLEAR_READ     = 8'h0E;
	localparam logic [7:0] OFS_STICKY_FLAGS          = 8'h60; // Seen only as a read strobe

	// Field positions in live_event_flags
	localparam int FLG_LEFT_HP     = 7;
	localparam int FLG_RIGHT_HP    = 6;
	localparam int FLG_LEFT_COM    = 5;
	localparam int FLG_RIGHT_COM   = 4;
	localparam int FLG_BUTTON      = 3;
	localparam int FLG_HEADSET     = 2;
	localparam int FLG_AGC_LEFT    = 1;
	localparam int FLG_AGC_RIGHT   = 0;

	// Field positions in pin1_function_control
	localparam int CTL_SEL_HI      = 7;
	localparam int CTL_SEL_LO      = 4;
	localparam int CTL_CLK_SRC     = 3;
	localparam int CTL_IRQ_REPEAT  = 2;
	localparam int CTL_GP_IN       = 1;
	localparam int CTL_GP_OUT      = 0;

	// Reset values
	localparam logic [7:0] RST_LIVE_EVENT_FLAGS = 8'h00;
	localparam logic [7:0] RST_PIN1_CONTROL     = 8'h00;

	// Function select codes
	localparam logic [3:0] SEL_DISABLED   = 4'h0;
	localparam logic [3:0] SEL_REC_WCLK   = 4'h1;
	localparam logic [3:0] SEL_DIV1       = 4'h2;
	localparam logic [3:0] SEL_DIV2       = 4'h3;
	localparam logic [3:0] SEL_DIV4       = 4'h4;
	localparam logic [3:0] SEL_DIV8       = 4'h5;
	localparam logic [3:0] SEL_SHORT_A    = 4'h6;
	localparam logic [3:0] SEL_SHORT_B    = 4'h7;
	localparam logic [3:0] SEL_GP_INPUT   = 4'h8;
	localparam logic [3:0] SEL_GP_OUTPUT  = 4'h9;
	localparam logic [3:0] SEL_DMIC_CLK   = 4'hA;
	localparam logic [3:0] SEL_BUS_WCLK   = 4'hB;
	localparam logic [3:0] SEL_BUTTON     = 4'hC;
	localparam logic [3:0] SEL_HS_BTN_A   = 4'hD;
	localparam logic [3:0] SEL_HS_BTN_B   = 4'hE;
	localparam logic [3:0] SEL_ALL_EVENTS = 4'hF;

	// Interrupt pulse timing
	localparam int CLK_MHZ          = 250;
	localparam int IRQ_PULSE_US     = 2000;
	localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_US * CLK_MHZ;
	localparam int IRQ_GAP_CYCLES   = IRQ_PULSE_CYCLES;

	// Divider width: divide by up to 8
	localparam int DIV_BITS = 3;

	// Live detector levels from the analogue side
	typedef struct packed {
		logic left_hp_driver;
		logic right_hp_driver;
		logic left_hp_common_driver;
		logic right_hp_common_driver;
		logic button;
		logic headset;
		logic agc_left_quiet;
		logic agc_right_quiet;
	} detect_t;

	// Event pulses feeding the interrupt generators
	typedef struct packed {
		logic short_circuit;
		logic button;
		logic headset;
		logic agc_noise;
	} event_t;

	// Control bus access, one byte wide
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage : pin_mux_pkg

`default_nettype wire

// file: rtl/clock_divider.sv
/*
 * Power-of-two clock divider for the pin's divided-clock modes.
 * Assumes the source is a clock-rate enable or level already in the clk_i
 * domain; produces divide by 1, 2, 4 and 8 of its toggle rate.
 */
`timescale 1ns/100ps
`default_nettype none

module clock_divider #(
	parameter int BITS = pin_mux_pkg::DIV_BITS
) (
	input  wire logic            clk_i,
	input  wire logic            resetn_i,
	input  wire logic            ce_i,
	input  wire logic            src_i,
	output logic [BITS:0]        taps_o
);

	logic            src_q;      // Previous source level
	logic [BITS-1:0] count;      // Ripple of rising edges

	wire rise = src_i & ~src_q;  // Rising edge of source

	// Count source rising edges; each bit toggles at half the previous rate
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			src_q <= 1'b0;
			count <= '0;
		end
		else if (ce_i)
		begin
			src_q <= src_i;
			if (rise)
				count <= count + BITS'(1);
		end
	end

	// Tap 0 is the registered source, tap k divides by 2**k
	assign taps_o = {count, src_q};

endmodule : clock_divider

`default_nettype wire

// file: rtl/irq_pulser.sv
/*
 * Interrupt pulse shaper: one 2 ms pulse per event, or repeated pulses
 * while the sticky flags stay unread.
 * Assumes event_i is a single-cycle pulse in the clk_i domain.
 */
`timescale 1ns/100ps
`default_nettype none

module irq_pulser #(
	parameter int PULSE_CYCLES = pin_mux_pkg::IRQ_PULSE_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic ce_i,
	input  wire logic event_i,
	input  wire logic repeat_i,
	input  wire logic ack_i,
	output logic      irq_o
);

	logic [31:0] count;    // Cycles left in current phase
	logic        pending;  // Repeat mode waits for host read

	// Pulse high for PULSE_CYCLES, low for the same in repeat mode
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			count   <= 32'h0;
			irq_o   <= 1'b0;
			pending <= 1'b0;
		end
		else if (ce_i)
		begin
			// New event wins over host acknowledge
			if (event_i)
				pending <= repeat_i;
			else if (ack_i)
				pending <= 1'b0;
			if (event_i && !irq_o)
			begin
				irq_o <= 1'b1;
				count <= 32'(PULSE_CYCLES - 1);
			end
			else if (count != 32'h0)
				count <= count - 32'h1;
			else if (irq_o)
			begin
				irq_o <= 1'b0;
				count <= 32'(PULSE_CYCLES - 1);
			end
			else if (pending && !ack_i)
			begin
				irq_o <= 1'b1;
				count <= 32'(PULSE_CYCLES - 1);
			end
		end
	end

endmodule : irq_pulser

`default_nettype wire

// file: rtl/pin1_event_mux.sv
/*
 * Live event flag register and function mux of multi-function pin one.
 * Holds the two registers, the button sticky bit, the interrupt shapers
 * and the pin output mux. Assumes detector levels and pin input come from
 * outside the clock domain; word clocks and modulator clock are levels
 * from other blocks of the device, also synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none

module pin1_event_mux #(
	parameter int PULSE_CYCLES = pin_mux_pkg::IRQ_PULSE_CYCLES
) (
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	input  wire logic                 ce_i,
	input  wire pin_mux_pkg::reg_req_t req_i,
	output logic [7:0]                rdata_o,
	input  wire pin_mux_pkg::detect_t detect_i,
	input  wire logic                 rec_wclk_i,
	input  wire logic                 bus_wclk_i,
	input  wire logic                 bus_wclk_master_i,
	input  wire logic                 dmic_clk_i,
	input  wire logic                 pll_clk_i,
	input  wire logic                 divmux_clk_i,
	input  wire logic                 pin_in_i,
	output logic                      pin_out_o,
	output logic                      pin_oe_n_o,
	output logic                      bus_wclk_o
);

	// Crossing into the core clock
	// Detector levels, the pin and the slow device clocks arrive with no
	// fixed phase to clk_i, so each passes two flops before any logic.
	// The slow clocks are sampled as levels, never used as clocks: each
	// level must last at least two core cycles or an edge is lost.
	// Pin modes that copy a level lag their source by the two sync cycles
	// plus the output register, divided clocks and shaped pulses by one cycle more; software never sees the difference.
	// bus_wclk_master_i comes from serial bus settings in this domain
	// and needs no synchroniser.

	// Two-stage synchronisers for every asynchronous level
	localparam int NSYNC = 14;
	logic [NSYNC-1:0] sync_a;   // First stage, read only by second
	logic [NSYNC-1:0] sync_b;   // Settled copies
	wire  [NSYNC-1:0] async_in = {detect_i, rec_wclk_i, bus_wclk_i,
	                              dmic_clk_i, pll_clk_i, divmux_clk_i,
	                              pin_in_i};

	// Capture all outside levels through two flops
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			sync_a <= '0;
			sync_b <= '0;
		end
		else if (ce_i)
		begin
			sync_a <= async_in;
			sync_b <= sync_a;
		end
	end

	// Bit order of the synchroniser matches the concatenation above;
	// any new input must be added at both places.

	// Named views of settled levels
	pin_mux_pkg::detect_t det;
	assign det = pin_mux_pkg::detect_t'(sync_b[13:6]);
	wire rec_wclk_s = sync_b[5];
	wire bus_wclk_s = sync_b[4];
	wire dmic_clk_s = sync_b[3];
	wire pll_clk_s  = sync_b[2];
	wire divmux_s   = sync_b[1];
	wire pin_in_s   = sync_b[0];

	// Control byte, high to low: select code, clock source, repeat
	// mode, pin input level, pin output level.
	// The input level bit has no write path, so a stale software value
	// can never mask what the pin shows.
	// Reset leaves the pin disabled and released, so nothing is driven
	// onto the board until software picks a role.

	// Register state
	logic [3:0] func_sel;      // Function select field
	logic       clk_src;       // Divided-clock source choice
	logic       irq_repeat;    // Pulse repeat mode
	logic       gp_out_val;    // Level driven in output mode
	logic       gp_in_val;     // Pin level seen in input mode
	logic       button_sticky; // Held button press
	logic       button_q;      // Previous button level
	logic [3:0] det_q;         // Previous event levels

	// Decode is purely combinational on the request word.
	// A read and a write in the same cycle are not expected; the host
	// bus issues one byte access at a time.
	// The clearing read and the sticky register read have no storage
	// here: they return zero and only act as strobes.

	// Bus decode
	wire rd_flags  = req_i.rd && req_i.addr == pin_mux_pkg::OFS_LIVE_EVENT_FLAGS;
	wire rd_ctrl   = req_i.rd && req_i.addr == pin_mux_pkg::OFS_PIN1_FUNCTION_CONTROL;
	wire rd_clear  = req_i.rd && req_i.addr == pin_mux_pkg::OFS_BUTTON_CLEAR_READ;
	wire wr_ctrl   = req_i.wr && req_i.addr == pin_mux_pkg::OFS_PIN1_FUNCTION_CONTROL;
	wire rd_sticky = req_i.rd && req_i.addr == pin_mux_pkg::OFS_STICKY_FLAGS;

	// Event edges drive the interrupt shapers, not the flag word.
	// The edge registers reset to zero, the idle level of every
	// detector, so no false event follows reset.
	// Short circuits on any of the four drivers count as one event:
	// a second short while the first is still present is not seen.

	// Rising edges of event sources
	wire short_any = det.left_hp_driver | det.right_hp_driver |
	                 det.left_hp_common_driver | det.right_hp_common_driver;
	wire [3:0] det_now = {short_any, det.button, det.headset,
	                      det.agc_left_quiet | det.agc_right_quiet};
	wire [3:0] ev_rise = det_now & ~det_q;
	wire button_rise = det.button & ~button_q;

	// Flag word is live except for the held button bit; a level that
	// flickers faster than two core cycles may never be shown.

	// Live flag word
	wire [7:0] flags = {det.left_hp_driver,
	                    det.right_hp_driver,
	                    det.left_hp_common_driver,
	                    det.right_hp_common_driver,
	                    button_sticky,
	                    det.headset,
	                    det.agc_left_quiet,
	                    det.agc_right_quiet};

	wire [7:0] ctrl = {func_sel, clk_src, irq_repeat, gp_in_val, gp_out_val};

	// Register writes; flags register has no write path
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			func_sel   <= pin_mux_pkg::RST_PIN1_CONTROL[7:4];
			clk_src    <= 1'b0;
			irq_repeat <= 1'b0;
			gp_out_val <= 1'b0;
		end
		else if (ce_i && wr_ctrl)
		begin
			func_sel   <= req_i.wdata[pin_mux_pkg::CTL_SEL_HI:pin_mux_pkg::CTL_SEL_LO];
			clk_src    <= req_i.wdata[pin_mux_pkg::CTL_CLK_SRC];
			irq_repeat <= req_i.wdata[pin_mux_pkg::CTL_IRQ_REPEAT];
			gp_out_val <= req_i.wdata[pin_mux_pkg::CTL_GP_OUT];
		end
	end

	// A press that lands in the same cycle as the clearing read must
	// not be lost, so the set has priority over the clear.
	// The pin input level is only refreshed in input mode, so the read
	// back value is frozen once the pin takes another role.

	// Button sticky bit: a new press wins over the clearing read
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			button_sticky <= 1'b0;
			button_q      <= 1'b0;
			det_q         <= 4'h0;
			gp_in_val     <= 1'b0;
		end
		else if (ce_i)
		begin
			button_q <= det.button;
			det_q    <= det_now;
			if (button_rise)
				button_sticky <= 1'b1;
			else if (rd_clear)
				button_sticky <= 1'b0;
			// Pin level sampled only in input mode
			if (func_sel == pin_mux_pkg::SEL_GP_INPUT)
				gp_in_val <= pin_in_s;
		end
	end

	// Read data stands until the next read; writes leave it alone.
	// Unmapped reads return zero rather than the last value, so a bad
	// address cannot be mistaken for a real register.

	// Read data register
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			rdata_o <= 8'h00;
		else if (ce_i)
		begin
			if (rd_flags)
				rdata_o <= flags;
			else if (rd_ctrl)
				rdata_o <= ctrl;
			else if (req_i.rd)
				rdata_o <= 8'h00;  // Unmapped reads give zero
		end
	end

	// Divided clocks are made by counting sampled source edges.
	// Trade-off: no second clock tree, at the cost of one core cycle
	// of jitter on every edge and a source limit near a quarter of the
	// core rate. Switching the source does not reset the counter, so
	// the first divided period after a switch may be short.

	// Divided clock source choice
	wire div_src = clk_src ? divmux_s : pll_clk_s;
	logic [pin_mux_pkg::DIV_BITS:0] taps;

	clock_divider #(
		.BITS    (pin_mux_pkg::DIV_BITS)
	) u_div (
		.clk_i   (clk_i),
		.resetn_i(resetn_i),
		.ce_i    (ce_i),
		.src_i   (div_src),
		.taps_o  (taps)
	);

	// One shaper per event class, so a pulse of one class cannot hide
	// a later event of another. The combined modes OR the shaped pulses,
	// which can merge two pulses into one longer high time.
	// Only a read of the sticky flag register ends repeated pulses;
	// reading the live flags does not.

	// Interrupt shapers, one per event class
	logic [3:0] irq;  // short, button, headset, agc
	wire  ack = rd_sticky;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_irq
			irq_pulser #(
				.PULSE_CYCLES(PULSE_CYCLES)
			) u_pulse (
				.clk_i   (clk_i),
				.resetn_i(resetn_i),
				.ce_i    (ce_i),
				.event_i (ev_rise[gi]),
				.repeat_i(irq_repeat),
				.ack_i   (ack),
				.irq_o   (irq[gi])
			);
		end
	endgenerate

	wire irq_short   = irq[3];
	wire irq_button  = det.button;  // Press length plus sync delay
	wire irq_headset = irq[1];
	wire irq_agc     = irq[0];
	wire irq_hs_btn  = irq_headset | irq[2];

	// Every code is decoded; the default branch only guards unknowns.
	// Released codes other than eleven drive the output value low as well as raising the
	// enable, so a board probe sees a clean level.
	// Code eleven releases the pin whenever the device is not master.

	// Pin output selection
	logic next_pin_out;
	logic next_pin_oe_n;
	always_comb
	begin
		next_pin_out  = 1'b0;
		next_pin_oe_n = 1'b0;
		case (func_sel)
			pin_mux_pkg::SEL_DISABLED:   next_pin_oe_n = 1'b1;
			pin_mux_pkg::SEL_REC_WCLK:   next_pin_out  = rec_wclk_s;
			pin_mux_pkg::SEL_DIV1:       next_pin_out  = taps[0];
			pin_mux_pkg::SEL_DIV2:       next_pin_out  = taps[1];
			pin_mux_pkg::SEL_DIV4:       next_pin_out  = taps[2];
			pin_mux_pkg::SEL_DIV8:       next_pin_out  = taps[3];
			pin_mux_pkg::SEL_SHORT_A,
			pin_mux_pkg::SEL_SHORT_B:    next_pin_out  = irq_short;
			pin_mux_pkg::SEL_GP_INPUT:   next_pin_oe_n = 1'b1;
			pin_mux_pkg::SEL_GP_OUTPUT:  next_pin_out  = gp_out_val;
			pin_mux_pkg::SEL_DMIC_CLK:   next_pin_out  = dmic_clk_s;
			pin_mux_pkg::SEL_BUS_WCLK:
			begin
				// Slave direction leaves the pin as input
				next_pin_out  = bus_wclk_s;
				next_pin_oe_n = ~bus_wclk_master_i;
			end
			pin_mux_pkg::SEL_BUTTON:     next_pin_out  = irq_button;
			pin_mux_pkg::SEL_HS_BTN_A,
			pin_mux_pkg::SEL_HS_BTN_B:   next_pin_out  = irq_hs_btn;
			pin_mux_pkg::SEL_ALL_EVENTS:
				next_pin_out = irq_hs_btn | irq_short | irq_agc;
			default:                     next_pin_oe_n = 1'b1;
		endcase
	end

	// All three pin outputs come straight from flops, so the pad never
	// sees a glitch from the select decode.
	// The word clock taken from the pin is forced low in other modes,
	// so the serial bus never runs from a stray pin level.

	// Registered pin drive; word clock in from pin when slaved
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			pin_out_o  <= 1'b0;
			pin_oe_n_o <= 1'b1;
			bus_wclk_o <= 1'b0;
		end
		else if (ce_i)
		begin
			pin_out_o  <= next_pin_out;
			pin_oe_n_o <= next_pin_oe_n;
			bus_wclk_o <= (func_sel == pin_mux_pkg::SEL_BUS_WCLK) ? pin_in_s : 1'b0;
		end
	end

endmodule : pin1_event_mux

`default_nettype wire

// file: verification/pin_partner.sv
/* Board-side model of pin one: resolves the wire level.
   Assumes a weak pull-down on the board and no contention. */
`timescale 1ns/100ps
`default_nettype none

module pin_partner (
	input  wire logic pin_out_i,
	input  wire logic pin_oe_n_i,
	input  wire logic drive_en_i,
	input  wire logic drive_val_i,
	output logic      pin_level_o
);
	// Device wins when enabled, then board driver, else pull-down
	assign pin_level_o = !pin_oe_n_i ? pin_out_i : drive_en_i ? drive_val_i : 1'b0;
endmodule : pin_partner

`default_nettype wire

// file: verification/pin1_event_mux_assertions.sv
/* Checker for pin1_event_mux, bound to its ports.
   Assumes ce_i stays high while checked. */
`timescale 1ns/100ps
`default_nettype none

module pin1_event_mux_checker #(
	parameter int PULSE_CYCLES = 8
) (
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire logic                  ce_i,
	input  wire pin_mux_pkg::reg_req_t req_i,
	input  wire logic [7:0]            rdata_o,
	input  wire pin_mux_pkg::detect_t  detect_i,
	input  wire logic                  rec_wclk_i,
	input  wire logic                  pin_out_o,
	input  wire logic                  pin_oe_n_o,
	input  wire logic                  bus_wclk_o
);
	logic [7:0]  ctl;    // Shadow of the control byte
	logic [2:0]  age;    // Cycles since last control write
	logic [31:0] hi_cnt; // Length of the current high run
	wire rd_flags = req_i.rd && req_i.addr == 8'h61;
	wire rd_ctl   = req_i.rd && req_i.addr == 8'h62;
	wire rd_clr   = req_i.rd && req_i.addr == 8'h0E;
	wire wr_ctl   = req_i.wr && req_i.addr == 8'h62;
	wire irq_sel  = ctl[7:4] inside {4'h6, 4'h7, 4'hD, 4'hE, 4'hF};
	logic        btn_q;  // Button detector level one cycle ago
	wire btn_low  = !detect_i.button && !btn_q;

	// Shadow state; age saturates so old settings stay trusted
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			ctl    <= 8'h00;
			age    <= 3'h0;
			hi_cnt <= 32'h0;
			btn_q  <= 1'b0;
		end
		else if (ce_i)
		begin
			ctl    <= wr_ctl ? req_i.wdata : ctl;
			age    <= wr_ctl ? 3'h0 : age + {2'h0, age != 3'h7};
			hi_cnt <= pin_out_o ? hi_cnt + 32'h1 : 32'h0;
			btn_q  <= detect_i.button;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	AST_RESET_OUT: assert property (disable iff (1'b0) !resetn_i && ce_i |=>
		rdata_o == 8'h00 && pin_oe_n_o && !pin_out_o && !bus_wclk_o)
		else $error("outputs not at reset values");
	AST_FLOAT: assert property (age != 3'h0 && (ctl[7:4] == 4'h0 || ctl[7:4] == 4'h8)
		|-> pin_oe_n_o)
		else $error("pin driven while released");
	AST_GP_DRIVE: assert property (age != 3'h0 && ctl[7:4] == 4'h9 |->
		!pin_oe_n_o && pin_out_o == ctl[0])
		else $error("output mode level wrong");
	AST_FLAGS_LIVE: assert property (rd_flags && $stable(detect_i)
		&& $past(detect_i, 2) == detect_i && $past(detect_i, 3) == detect_i
		&& $past(resetn_i) && $past(resetn_i, 2) && $past(resetn_i, 3)
		|=> {rdata_o[7:4], rdata_o[2:0]} == {$past(detect_i[7:4]), $past(detect_i[2:0])})
		else $error("live flags differ from detectors");
	AST_CTRL_READ: assert property (rd_ctl |=> rdata_o[7:2] == $past(ctl[7:2])
		&& rdata_o[0] == $past(ctl[0]))
		else $error("control readback wrong");
	AST_BUTTON_CLR: assert property (rd_clr && btn_low && !$past(detect_i.button, 2)
		##2 rd_flags && btn_low |=> !rdata_o[3])
		else $error("button flag not cleared");
	AST_REC_WCLK: assert property (age[2] && ctl[7:4] == 4'h1 |->
		!pin_oe_n_o && pin_out_o == $past(rec_wclk_i, 3))
		else $error("record word clock not on pin");
	AST_IRQ_WIDTH: assert property (age[2] && irq_sel && !ctl[2] && $fell(pin_out_o)
		|-> hi_cnt == PULSE_CYCLES)
		else $error("interrupt pulse width wrong");

	// Main scenarios reached
	COV_FLAGS: cover property (rd_flags);
	COV_IRQ: cover property (irq_sel && $fell(pin_out_o));
	COV_WCLK: cover property (age[2] && ctl[7:4] == 4'h1);
endmodule : pin1_event_mux_checker

bind pin1_event_mux pin1_event_mux_checker #(.PULSE_CYCLES(PULSE_CYCLES)) checker_i (
	.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o),
	.detect_i(detect_i), .rec_wclk_i(rec_wclk_i), .pin_out_o(pin_out_o),
	.pin_oe_n_o(pin_oe_n_o), .bus_wclk_o(bus_wclk_o));

`default_nettype wire

// file: verification/pin1_event_mux_test.sv
/* Bench for pin1_event_mux: registers, flags, pin modes, interrupts.
   Assumes the checker is bound and pin_partner resolves the pin. */
`timescale 1ns/100ps
`default_nettype none

module pin1_event_mux_test;
	localparam int PULSE = 8; // Shortened interrupt pulse
	logic                  clk_i;
	logic                  resetn_i;
	pin_mux_pkg::reg_req_t req;
	pin_mux_pkg::detect_t  det;
	logic [7:0]            rdata, got;
	logic                  rec_wclk, bus_wclk, dmic, pll, divmux;
	logic                  master, drv_en, drv_val;
	logic                  pin_out, pin_oe_n, pin_lvl, wclk_in;
	int                    fails, tests_run, w;

	pin1_event_mux #(.PULSE_CYCLES(PULSE)) pin1_event_mux_i (
		.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .req_i(req), .rdata_o(rdata),
		.detect_i(det), .rec_wclk_i(rec_wclk), .bus_wclk_i(bus_wclk),
		.bus_wclk_master_i(master), .dmic_clk_i(dmic), .pll_clk_i(pll),
		.divmux_clk_i(divmux), .pin_in_i(pin_lvl), .pin_out_o(pin_out),
		.pin_oe_n_o(pin_oe_n), .bus_wclk_o(wclk_in));
	pin_partner pin_partner_i (.pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n),
		.drive_en_i(drv_en), .drive_val_i(drv_val), .pin_level_o(pin_lvl));

	// Core clock, 4 ns period
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Slow sources, each moving 1 ns after a core edge
	initial
	begin
		{rec_wclk, bus_wclk, dmic, pll, divmux} = 5'h00;
		#3;
		fork
			forever #20 rec_wclk = ~rec_wclk;
			forever #28 bus_wclk = ~bus_wclk;
			forever #12 dmic = ~dmic;
			forever #16 pll = ~pll;
			forever #24 divmux = ~divmux;
		join
	end

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] act);
		tests_run++;
		if (act !== exp)
		begin
			fails++;
			$display("FAIL %s expected %0h seen %0h", what, exp, act);
		end
	endtask : cmp

	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick

	// One register access; read data is taken right after its edge
	task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
		tick(1);
		req = '{r, !r, a, d};
		tick(1);
		req = '0;
		got = rdata;
	endtask : acc

	// Bounded wait for a pin level, counting cycles
	task automatic wait_pin(input logic v, output int cnt);
		cnt = 0;
		while (pin_lvl !== v && cnt < 400)
		begin
			tick(1);
			cnt++;
		end
		if (cnt == 400)
			cmp("pin wait", 0, 1);
	endtask : wait_pin

	task automatic t_regs;
		acc(1, 8'h61, 8'h00);
		cmp("flags at reset", 8'h00, got);
		acc(1, 8'h62, 8'h00);
		cmp("control at reset", 8'h00, got);
		cmp("pin released", 1'b1, pin_oe_n);
		acc(0, 8'h61, 8'hFF);
		acc(1, 8'h61, 8'h00);
		cmp("flags unwritable", 8'h00, got);
		for (int i = 0; i < 8; i++)
		begin
			det = (i == 3) ? 8'h00 : 8'h01 << i;
			tick(4);
			acc(1, 8'h61, 8'h00);
			cmp("live flag", det, got);
		end
		det = 8'h08;
		tick(4);
		det = 8'h00;
		tick(4);
		acc(1, 8'h61, 8'h00);
		cmp("button held", 8'h08, got);
		acc(1, 8'h0E, 8'h00);
		acc(1, 8'h61, 8'h00);
		cmp("button cleared", 8'h00, got);
		$display("done registers");
	endtask : t_regs

	task automatic t_pins;
		acc(0, 8'h62, 8'h8C);
		{drv_en, drv_val} = 2'h3;
		tick(6);
		acc(1, 8'h62, 8'h00);
		cmp("input readback", 8'h8E, got);
		cmp("input released", 1'b1, pin_oe_n);
		drv_en = 1'b0;
		acc(0, 8'h62, 8'h91);
		tick(2);
		cmp("output high", 2'h1, {pin_oe_n, pin_lvl});
		acc(0, 8'h62, 8'h90);
		tick(2);
		cmp("output low", 2'h0, {pin_oe_n, pin_lvl});
		master = 1'b0;
		acc(0, 8'h62, 8'hB0);
		tick(2);
		drv_en = 1'b1;
		tick(6);
		cmp("word clock in high", 2'h3, {pin_oe_n, wclk_in});
		drv_val = 1'b0;
		tick(6);
		cmp("word clock in low", 2'h2, {pin_oe_n, wclk_in});
		drv_en = 1'b0;
		master = 1'b1;
		$display("done pin modes");
	endtask : t_pins

	task automatic t_clocks;
		logic [7:0] code [9] = '{8'h10, 8'hA0, 8'hB0, 8'h20, 8'h30, 8'h40, 8'h50, 8'h28, 8'h58};
		int         per  [9] = '{10, 6, 14, 8, 16, 32, 64, 12, 96};
		int         a, p;
		foreach (code[i])
		begin
			acc(0, 8'h62, code[i]);
			tick(4);
			wait_pin(1'b0, a);
			wait_pin(1'b1, a);
			wait_pin(1'b0, a);
			wait_pin(1'b1, p);
			cmp("pin clock period", per[i], a + p);
		end
		$display("done clocks");
	endtask : t_clocks

	task automatic t_irq;
		logic [7:0] code [5] = '{8'h60, 8'h70, 8'hD0, 8'hE0, 8'hF0};
		logic [7:0] ev   [5] = '{8'h80, 8'h10, 8'h04, 8'h04, 8'h02};
		foreach (code[i])
		begin
			acc(0, 8'h62, code[i]);
			tick(4);
			det = ev[i];
			wait_pin(1'b1, w);
			wait_pin(1'b0, w);
			cmp("pulse width", PULSE, w);
			det = 8'h00;
			tick(4);
		end
		acc(0, 8'h62, 8'hC0);
		det = 8'h08;
		tick(5);
		cmp("button irq high", 1'b1, pin_lvl);
		det = 8'h00;
		tick(5);
		cmp("button irq low", 1'b0, pin_lvl);
		acc(1, 8'h0E, 8'h00);
		acc(0, 8'h62, 8'h64);
		tick(4);
		det = 8'h40;
		wait_pin(1'b1, w);
		wait_pin(1'b0, w);
		wait_pin(1'b1, w);
		cmp("repeat gap", PULSE, w);
		acc(1, 8'h60, 8'h00);
		det = 8'h00;
		wait_pin(1'b0, w);
		tick(PULSE + 2);
		cmp("repeat stopped", 1'b0, pin_lvl);
		$display("done interrupts");
	endtask : t_irq

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// Main sequence after a two-cycle reset
	initial
	begin
		resetn_i = 1'b0;
		req = '0;
		det = '0;
		{master, drv_en, drv_val} = 3'h4;
		fails = 0;
		tests_run = 0;
		tick(2);
		resetn_i = 1'b1;
		t_regs();
		t_pins();
		t_clocks();
		t_irq();
		conclude();
	end

	// Watchdog, well beyond the thousand or so cycles needed
	initial
	begin
		#(40000 * 4);
		cmp("watchdog", 0, 1);
		conclude();
	end
endmodule : pin1_event_mux_test

`default_nettype wire
